// ===== hdl/rstcap_params.svh
// Constants for the reset strap capture block
`ifndef RSTCAP_PARAMS_SVH
`define RSTCAP_PARAMS_SVH

`define RSTCAP_ADDR_W 4
`define RSTCAP_OFF_STRAPS 4'h0
`define RSTCAP_OFF_CTRL 4'h4
`define RSTCAP_OFF_STATUS 4'h8
`define RSTCAP_OFF_ID 4'hC
`define RSTCAP_ID_VALUE 32'h00005A11
`define RSTCAP_BIT_HRST_REQ 0
`define RSTCAP_BIT_PIN_LOW 0
`define RSTCAP_BIT_CAPTURED 1
`define RSTCAP_BIT_PIN_SEEN 2
`define RSTCAP_BOOT_HOST_NOPLL 4'h0
`define RSTCAP_BOOT_SPI_ALT 4'hC
`define RSTCAP_HRST_PULSE_NS 1000
`define RSTCAP_CLK_MHZ 20
`define RSTCAP_HRST_CYC ((`RSTCAP_HRST_PULSE_NS * `RSTCAP_CLK_MHZ) / 1000)
`define RSTCAP_RESP_OKAY 2'h0
`define RSTCAP_RESP_SLVERR 2'h2

`endif

// ===== hdl/rstcap_pkg.sv
// Types for the reset strap capture block
package rstcap_pkg;
	typedef struct packed {
		logic [3:0] boot_mode_select;
		logic watchdog_enable_strap;
		logic host_strobe_polarity_strap;
		logic host_width_strap;
	} rstcap_straps_t;

	typedef struct packed {
		logic watchdog_en;
		logic strobe_active_high;
		logic width_8bit;
		logic boot_host_no_pll;
		logic boot_spi_alt_pins;
	} rstcap_cfg_t;

	typedef enum logic [1:0] {
		RSTCAP_WAIT_POR,
		RSTCAP_RUN
	} rstcap_state_t;
endpackage : rstcap_pkg

// ===== hdl/rstcap_top.sv
// Reset strap capture with hard reset pin and AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rstcap_params.svh"

// Behaviour
// - Capture all strap pins on the rising edge ending power-on reset.
// - Watchdog enable output follows captured watchdog strap: 0 off, 1 on.
// - Captured polarity strap 0 means strobes active low, 1 active high.
// - Captured width strap 0 selects 16-bit host port, 1 selects 8-bit.
// - Hard reset pin open-drain: device only pulls low, also reads it.
// - Boot mode 0000 boots from host port, PLL bypassed, either width.
// - Boot mode 1100 selects serial boot over the alternative pin set.
module rstcap_top (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	// Board pins
	input wire logic power_on_reset_in_n_i,
	input wire logic [3:0] boot_mode_select_i,
	input wire logic watchdog_enable_strap_i,
	input wire logic host_strobe_polarity_strap_i,
	input wire logic host_width_strap_i,
	input wire logic hard_reset_pin_i,
	output logic hard_reset_pin_o,
	output logic hard_reset_pin_oe_o,
	// Device internal requests and results
	input wire logic hard_reset_req_i,
	output logic hard_reset_in_o,
	output logic cfg_valid_o,
	output rstcap_pkg::rstcap_straps_t straps_o,
	output rstcap_pkg::rstcap_cfg_t cfg_o,
	// AXI4-Lite slave
	input wire logic [`RSTCAP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`RSTCAP_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] pin_s1;
	logic [7:0] pin_s2;
	logic [6:0] strap_raw_s;
	wire por_n_s = pin_s2[7];
	wire hrst_pin_s = pin_s2[6];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			// Idle levels: reset wire released high, power-on reset asserted
			pin_s1 <= 8'h40;
			pin_s2 <= 8'h40;
		end else if (clk_en_i) begin
			pin_s1 <= {power_on_reset_in_n_i, hard_reset_pin_i, boot_mode_select_i[3:0],
				watchdog_enable_strap_i, host_strobe_polarity_strap_i};
			pin_s2 <= pin_s1;
		end
	end

	// Width strap synchronised separately to keep the vector at eight bits
	logic width_s1;
	logic width_s2;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			width_s1 <= 1'b0;
			width_s2 <= 1'b0;
		end else if (clk_en_i) begin
			width_s1 <= host_width_strap_i;
			width_s2 <= width_s1;
		end
	end

	assign strap_raw_s = {pin_s2[5:0], width_s2};

	// ****************************************
	// Power-on reset edge and capture
	// ****************************************
	logic por_n_d;
	rstcap_pkg::rstcap_state_t state;
	rstcap_pkg::rstcap_state_t next_state;
	rstcap_pkg::rstcap_straps_t straps;
	logic captured;
	wire por_rise = por_n_s && !por_n_d;
	wire por_active = !por_n_s;
	wire capture_now = (state == rstcap_pkg::RSTCAP_WAIT_POR) && por_rise;

	always_comb begin
		next_state = state;
		case (state)
			rstcap_pkg::RSTCAP_WAIT_POR: begin
				if (por_rise) begin
					next_state = rstcap_pkg::RSTCAP_RUN;
				end
			end
			rstcap_pkg::RSTCAP_RUN: begin
				// Only a new power-on reset reopens the capture window
				if (por_active) begin
					next_state = rstcap_pkg::RSTCAP_WAIT_POR;
				end
			end
			default: begin
				next_state = rstcap_pkg::RSTCAP_WAIT_POR;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state <= rstcap_pkg::RSTCAP_WAIT_POR;
			por_n_d <= 1'b0;
		end else if (clk_en_i) begin
			state <= next_state;
			por_n_d <= por_n_s;
		end
	end

	// Straps held between power-on resets; later pin changes are ignored
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			straps <= '0;
			captured <= 1'b0;
		end else if (clk_en_i) begin
			if (capture_now) begin
				straps <= rstcap_pkg::rstcap_straps_t'(strap_raw_s);
				captured <= 1'b1;
			end else if (por_active) begin
				captured <= 1'b0;
			end
		end
	end

	// ****************************************
	// Decoded configuration
	// ****************************************
	rstcap_pkg::rstcap_cfg_t next_cfg;
	wire cfg_wdt = straps.watchdog_enable_strap;
	wire cfg_pol = straps.host_strobe_polarity_strap;
	wire cfg_w8 = straps.host_width_strap;
	wire cfg_host = straps.boot_mode_select == `RSTCAP_BOOT_HOST_NOPLL;
	wire cfg_spi_alt = straps.boot_mode_select == `RSTCAP_BOOT_SPI_ALT;
	assign next_cfg = '{watchdog_en: cfg_wdt, strobe_active_high: cfg_pol,
		width_8bit: cfg_w8, boot_host_no_pll: cfg_host, boot_spi_alt_pins: cfg_spi_alt};

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cfg_o <= '0;
			straps_o <= '0;
			cfg_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			cfg_o <= captured ? next_cfg : '0;
			straps_o <= straps;
			cfg_valid_o <= captured;
		end
	end

	// ****************************************
	// Hard reset pin, open drain
	// ****************************************
	localparam int unsigned HRST_CYC = (`RSTCAP_HRST_CYC < 1) ? 1 : `RSTCAP_HRST_CYC;
	logic [15:0] hrst_cnt;
	logic sw_hrst_req;
	// Power-on reset also pulls the wire, stretched by one full pulse
	wire hrst_start = hard_reset_req_i || sw_hrst_req || por_active;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			hrst_cnt <= 16'h0000;
		end else if (clk_en_i) begin
			if (hrst_start) begin
				hrst_cnt <= 16'(HRST_CYC);
			end else if (hrst_cnt != 16'h0000) begin
				hrst_cnt <= hrst_cnt - 16'h0001;
			end
		end
	end

	// Output value is always low; only the enable moves
	assign hard_reset_pin_o = 1'b0;
	assign hard_reset_pin_oe_o = hrst_cnt != 16'h0000;
	assign hard_reset_in_o = !hrst_pin_s;

	// Own pull still shows on the synchronised wire for two cycles after release
	logic [1:0] oe_hist;
	wire own_pull = hard_reset_pin_oe_o || (|oe_hist);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			oe_hist <= 2'h0;
		end else if (clk_en_i) begin
			oe_hist <= {oe_hist[0], hard_reset_pin_oe_o};
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_held;
	logic w_held;
	logic [`RSTCAP_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic pin_seen;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_ctrl = aw_addr == `RSTCAP_OFF_CTRL;
	wire wr_ok = wr_ctrl || (aw_addr == `RSTCAP_OFF_STRAPS) || (aw_addr == `RSTCAP_OFF_STATUS)
		|| (aw_addr == `RSTCAP_OFF_ID);
	wire clr_seen = do_write && (aw_addr == `RSTCAP_OFF_STATUS) && w_strb[0]
		&& w_data[`RSTCAP_BIT_PIN_SEEN];
	wire [31:0] rd_straps = {25'h0, straps};
	wire [31:0] rd_status = {29'h0, pin_seen, captured, hrst_pin_s == 1'b0};
	wire rd_hit = (s_axi_araddr == `RSTCAP_OFF_STRAPS) || (s_axi_araddr == `RSTCAP_OFF_CTRL)
		|| (s_axi_araddr == `RSTCAP_OFF_STATUS) || (s_axi_araddr == `RSTCAP_OFF_ID);
	wire [31:0] rd_mux = (s_axi_araddr == `RSTCAP_OFF_STRAPS) ? rd_straps :
		(s_axi_araddr == `RSTCAP_OFF_CTRL) ? {31'h0, sw_hrst_req} :
		(s_axi_araddr == `RSTCAP_OFF_STATUS) ? rd_status :
		(s_axi_araddr == `RSTCAP_OFF_ID) ? `RSTCAP_ID_VALUE : 32'h00000000;

	// Single-entry holding; ready drops while a word waits
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (clk_en_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Hardware set of the pin-seen flag wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RSTCAP_RESP_OKAY;
			sw_hrst_req <= 1'b0;
			pin_seen <= 1'b0;
		end else if (clk_en_i) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RSTCAP_RESP_OKAY : `RSTCAP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Self-clearing one-cycle request
			sw_hrst_req <= do_write && wr_ctrl && w_strb[0] && w_data[`RSTCAP_BIT_HRST_REQ];
			if (!hrst_pin_s && !own_pull) begin
				pin_seen <= 1'b1;
			end else if (clr_seen) begin
				pin_seen <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RSTCAP_RESP_OKAY;
		end else if (clk_en_i) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `RSTCAP_RESP_OKAY : `RSTCAP_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : rstcap_top

// ===== verification/rstcap_checker.sv
// Port-level assertions for the reset strap capture block
`timescale 1ns/1ps
module rstcap_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Pins and requests
	input wire logic power_on_reset_in_n_i,
	input wire logic hard_reset_pin_i,
	input wire logic hard_reset_pin_o,
	input wire logic hard_reset_pin_oe_o,
	input wire logic hard_reset_req_i,
	// Results
	input wire logic hard_reset_in_o,
	input wire logic cfg_valid_o,
	input rstcap_pkg::rstcap_straps_t straps_o,
	input rstcap_pkg::rstcap_cfg_t cfg_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ****************************************
	// Properties
	// ****************************************
	sequence s_por_release;
		!power_on_reset_in_n_i ##1 power_on_reset_in_n_i;
	endsequence
	sequence s_por_held;
		!power_on_reset_in_n_i [*5];
	endsequence
	property p_capture;
		s_por_release |-> ##[1:5] cfg_valid_o;
	endproperty
	property p_por_low;
		s_por_held |-> !cfg_valid_o && hard_reset_pin_oe_o;
	endproperty
	property p_hold;
		cfg_valid_o && $past(cfg_valid_o) |-> $stable(straps_o) && $stable(cfg_o);
	endproperty
	property p_wdt;
		cfg_valid_o |-> cfg_o.watchdog_en == straps_o.watchdog_enable_strap;
	endproperty
	property p_pol;
		cfg_valid_o |-> cfg_o.strobe_active_high == straps_o.host_strobe_polarity_strap;
	endproperty
	property p_width;
		cfg_valid_o |-> cfg_o.width_8bit == straps_o.host_width_strap;
	endproperty
	property p_boot0;
		cfg_valid_o |-> cfg_o.boot_host_no_pll == (straps_o.boot_mode_select == 4'h0);
	endproperty
	property p_bootc;
		cfg_valid_o |-> cfg_o.boot_spi_alt_pins == (straps_o.boot_mode_select == 4'hC);
	endproperty
	property p_od;
		!hard_reset_pin_o;
	endproperty
	property p_req;
		hard_reset_req_i |-> ##[1:3] hard_reset_pin_oe_o;
	endproperty
	property p_pin_in;
		!hard_reset_pin_i [*3] |-> hard_reset_in_o;
	endproperty
	a_capture: assert property (p_capture) else $error("no capture after release");
	a_por_low: assert property (p_por_low) else $error("bad state in power-on reset");
	a_hold: assert property (p_hold) else $error("captured straps changed");
	a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
	a_pol: assert property (p_pol) else $error("strobe polarity wrong");
	a_width: assert property (p_width) else $error("port width wrong");
	a_boot0: assert property (p_boot0) else $error("host boot flag wrong");
	a_bootc: assert property (p_bootc) else $error("serial boot flag wrong");
	a_od: assert property (p_od) else $error("pin driven high");
	a_req: assert property (p_req) else $error("no pull after request");
	a_pin_in: assert property (p_pin_in) else $error("low wire not seen");
endmodule : rstcap_checker

bind rstcap_top rstcap_checker u_chk (.sys_clk_i, .rst_n_i, .power_on_reset_in_n_i,
	.hard_reset_pin_i, .hard_reset_pin_o, .hard_reset_pin_oe_o, .hard_reset_req_i,
	.hard_reset_in_o, .cfg_valid_o, .straps_o, .cfg_o);

// ===== verification/rstcap_board.sv
// Board model: strap resistors, power-on reset source, open-drain reset wire
`timescale 1ns/1ps
module rstcap_board (
	// Clock
	input wire logic sys_clk_i,
	// Device side of the wire
	input wire logic hard_reset_pin_o,
	input wire logic hard_reset_pin_oe_o,
	// Board pins
	output logic power_on_reset_in_n_o,
	output rstcap_pkg::rstcap_straps_t straps_o,
	output logic hard_reset_wire_o
);
	logic ext_pull = 1'b0;
	// Pull-up wire; every party may only sink it
	assign hard_reset_wire_o = !((hard_reset_pin_oe_o && !hard_reset_pin_o) || ext_pull);
	initial begin
		power_on_reset_in_n_o = 1'b0;
		straps_o = '0;
	end
	task automatic por_cycle(input rstcap_pkg::rstcap_straps_t s);
		power_on_reset_in_n_o <= 1'b0;
		straps_o <= s;
		repeat (10) @(posedge sys_clk_i);
		power_on_reset_in_n_o <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		// Straps no longer held; show the inverse
		straps_o <= ~s;
	endtask : por_cycle
endmodule : rstcap_board

// ===== verification/tb_reset_strap_capture.sv
// Self-checking testbench for the reset strap capture block
`timescale 1ns/1ps
`include "rstcap_params.svh"
module tb_reset_strap_capture;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, hard_reset_req_i = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] resp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic power_on_reset_in_n_i, hard_reset_pin_i, hard_reset_pin_o, hard_reset_pin_oe_o;
	logic hard_reset_in_o, cfg_valid_o;
	rstcap_pkg::rstcap_straps_t strp, straps_o;
	rstcap_pkg::rstcap_cfg_t cfg_o;
	int mismatches = 0, n_tests = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	rstcap_board board (.sys_clk_i, .hard_reset_pin_o, .hard_reset_pin_oe_o,
		.power_on_reset_in_n_o(power_on_reset_in_n_i), .straps_o(strp),
		.hard_reset_wire_o(hard_reset_pin_i));
	rstcap_top dut (.sys_clk_i, .rst_n_i, .clk_en_i(1'b1), .power_on_reset_in_n_i,
		.boot_mode_select_i(strp.boot_mode_select),
		.watchdog_enable_strap_i(strp.watchdog_enable_strap),
		.host_strobe_polarity_strap_i(strp.host_strobe_polarity_strap),
		.host_width_strap_i(strp.host_width_strap), .hard_reset_pin_i, .hard_reset_pin_o,
		.hard_reset_pin_oe_o, .hard_reset_req_i, .hard_reset_in_o, .cfg_valid_o, .straps_o,
		.cfg_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge sys_clk_i);
			aw = aw || (s_axi_awvalid && s_axi_awready);
			w = w || (s_axi_wvalid && s_axi_wready);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(posedge sys_clk_i); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge sys_clk_i);
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk_i); while (!(s_axi_arvalid && s_axi_arready));
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk_i); while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge sys_clk_i);
	endtask : axi_rd
	function automatic rstcap_pkg::rstcap_cfg_t exp_cfg(input rstcap_pkg::rstcap_straps_t s);
		exp_cfg = {s.watchdog_enable_strap, s.host_strobe_polarity_strap, s.host_width_strap,
			s.boot_mode_select == 4'h0, s.boot_mode_select == 4'hC};
	endfunction : exp_cfg
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		rstcap_pkg::rstcap_straps_t s;
		logic [31:0] d;
		d = $urandom(32'h6BEBE858);
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			s = 7'($urandom);
			if (i < 2) s.boot_mode_select = i ? 4'hC : 4'h0;
			board.por_cycle(s);
			repeat (2) @(posedge sys_clk_i);
			check(32'(straps_o), 32'(s));
			check(32'(cfg_o), 32'(exp_cfg(s)));
			check(32'(cfg_valid_o), 32'h1);
			axi_wr(`RSTCAP_OFF_STRAPS, $urandom);
			axi_rd(`RSTCAP_OFF_STRAPS, d);
			check(d, 32'(s));
		end
		axi_rd(`RSTCAP_OFF_ID, d);
		check(d, `RSTCAP_ID_VALUE);
		check(32'(resp), 32'(`RSTCAP_RESP_OKAY));
		axi_wr(`RSTCAP_OFF_CTRL, 32'h1);
		repeat (3) @(posedge sys_clk_i);
		check(32'({hard_reset_pin_oe_o, hard_reset_in_o}), 32'h3);
		repeat (`RSTCAP_HRST_CYC + 3) @(posedge sys_clk_i);
		check(32'({hard_reset_pin_oe_o, hard_reset_in_o}), 32'h0);
		hard_reset_req_i <= 1'b1;
		@(posedge sys_clk_i);
		hard_reset_req_i <= 1'b0;
		@(posedge sys_clk_i);
		check(32'(hard_reset_pin_oe_o), 32'h1);
		repeat (`RSTCAP_HRST_CYC + 3) @(posedge sys_clk_i);
		// Own pulses must not mark the wire as pulled from outside
		axi_rd(`RSTCAP_OFF_STATUS, d);
		check(32'(d[2:0]), 32'h2);
		board.ext_pull <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		check(32'({hard_reset_pin_oe_o, hard_reset_in_o}), 32'h1);
		board.ext_pull <= 1'b0;
		axi_rd(`RSTCAP_OFF_STATUS, d);
		check(32'(d[2:1]), 32'h3);
		axi_wr(`RSTCAP_OFF_STATUS, 32'h4);
		axi_rd(`RSTCAP_OFF_STATUS, d);
		check(32'(d[2]), 32'h0);
		axi_wr(4'h2, 32'h0);
		check(32'(resp), 32'(`RSTCAP_RESP_SLVERR));
		axi_rd(4'h6, d);
		check(d, 32'h00000000);
		check(32'(resp), 32'(`RSTCAP_RESP_SLVERR));
		// Control bit ignored when its byte lane is not enabled
		s_axi_wstrb <= 4'h0;
		axi_wr(`RSTCAP_OFF_CTRL, 32'h1);
		repeat (3) @(posedge sys_clk_i);
		check(32'(hard_reset_pin_oe_o), 32'h0);
		s_axi_wstrb <= 4'hF;
		test_done();
	end
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		mismatches++;
		test_done();
	end
endmodule : tb_reset_strap_capture
